//--- rtl/switcher_fault_autorestart_ctrl.sv
// Purpose: Switch gating, blanking, supply regulator control and fault auto-restart
// Assumes: All comparator flags are synchronous and glitch-free
// Notes: Long counts are parameters so simulation can shorten them
`timescale 1ns/100ps
module switcher_fault_autorestart_ctrl
    import switcher_pkg::*;
#(
    parameter int unsigned OVERLOAD_CNT = OVERLOAD_CYCLES,
    parameter int unsigned RESTART_CNT = RESTART_CYCLES,
    parameter int unsigned SOFT_START_CNT = SOFT_START_CYCLES,
    parameter int unsigned PERIOD_CNT = PERIOD_CYCLES,
    parameter int unsigned MAX_ON_CNT = MAX_ON_CYCLES,
    parameter int unsigned BLANK_CNT = BLANKING_CYCLES
) (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    // Analog front end flags
    input wire front_flags_s i_flags,
    // Power switch and supply control
    output logic o_switch_on,
    output logic o_sense_enable,
    output logic o_charge_current_source,
    output logic o_supply_regulator,
    output logic [RAMP_W-1:0] o_current_ramp,
    // Status
    output fault_s o_fault,
    output phase_e o_phase
);

    localparam int TW = 25;
    localparam int PW = 16;

    // Whole state of the block
    typedef struct packed {
        phase_e phase;
        logic [TW-1:0] timer;       // Soft-start or restart timer
        logic [TW-1:0] ovl_timer;   // Overload delay
        logic [PW-1:0] cyc;         // Position within switching period
        logic [PW-1:0] period;      // Length of current period
        logic [15:0] lfsr;          // Free-running dither source
        logic sw_on;
        logic cycle_abnormal;       // Abnormal level seen this cycle
        logic [1:0] abn_cnt;
        logic thermal_hold;
        fault_s fault;
        logic [RAMP_W-1:0] ramp;
        logic chg;
        logic reg_on;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic blank_active;
    logic period_end;
    logic any_fault;
    logic switching;
    logic [PW-1:0] dither;

    // Helper terms
    assign blank_active = st_r.cyc < PW'(BLANK_CNT);
    assign period_end = st_r.cyc >= st_r.period - 16'h0001;
    assign switching = (st_r.phase == ST_SOFT) || (st_r.phase == ST_RUN);
    assign dither = {11'h000, st_r.lfsr[4:0] ^ {4'h0, i_flags.feedback_dither}};

    // Next-state logic
    always_comb begin
        logic [TW-1:0] ss_step;
        fault_s f;
        ss_step = TW'(SOFT_START_CNT / (1 << RAMP_W));
        f = '0;
        st_nxt = st_r;
        // Free-running oscillator keeps stepping in every phase
        st_nxt.lfsr = st_r.lfsr[0] ? ((st_r.lfsr >> 1) ^ LFSR_TAPS) : (st_r.lfsr >> 1);
        // Regulator off whenever external bias is above regulation
        st_nxt.reg_on = !i_flags.supply_above_reg;

        // Switching cycle timing
        if (switching) begin
            if (period_end) begin
                st_nxt.cyc = '0;
                // New period picked around the nominal frequency
                st_nxt.period = PW'(PERIOD_CNT - DITHER_SPAN / 2) + dither;
                st_nxt.sw_on = 1'b1;
                st_nxt.cycle_abnormal = 1'b0;
                // Counter clears on a cycle without abnormal current
                if (st_r.cycle_abnormal) begin
                    st_nxt.abn_cnt = st_r.abn_cnt + 2'h1;
                end else begin
                    st_nxt.abn_cnt = 2'h0;
                end
            end else begin
                st_nxt.cyc = st_r.cyc + 16'h0001;
                // Sense comparator only ends pulse past blanking
                if (st_r.sw_on && !blank_active && i_flags.sense_trip) begin
                    st_nxt.sw_on = 1'b0;
                end
                if (st_r.cyc >= PW'(MAX_ON_CNT)) begin
                    st_nxt.sw_on = 1'b0;
                end
                if (st_r.sw_on && !blank_active && i_flags.sense_abnormal) begin
                    st_nxt.cycle_abnormal = 1'b1;
                end
            end
        end else begin
            st_nxt.cyc = '0;
            st_nxt.sw_on = 1'b0;
        end

        // Overload delay restarts whenever the level drops
        if (switching && i_flags.comp_overload) begin
            if (st_r.ovl_timer < TW'(OVERLOAD_CNT)) begin
                st_nxt.ovl_timer = st_r.ovl_timer + 1'b1;
            end
        end else begin
            st_nxt.ovl_timer = '0;
        end

        // Thermal hold released only after cooling
        if (i_flags.temp_hot) begin
            st_nxt.thermal_hold = 1'b1;
        end else if (i_flags.temp_cooled) begin
            st_nxt.thermal_hold = 1'b0;
        end

        // Fault detection while switching
        f.overload_guard = st_r.ovl_timer >= TW'(OVERLOAD_CNT);
        f.abnormal_overcurrent_guard = period_end && st_r.cycle_abnormal
            && (st_r.abn_cnt == ABN_TRIP_COUNT);
        f.thermal_guard = i_flags.temp_hot || st_r.thermal_hold;
        f.supply_overvoltage_guard = i_flags.supply_over;
        // Open-loop guard blind during soft-start
        f.open_loop_guard = i_flags.feedback_low && (st_r.phase == ST_RUN);
        f.supply_lockout = i_flags.supply_stop;
        any_fault = |f;

        // Supply and auto-restart sequence
        case (st_r.phase)
            ST_CHARGE: begin
                // Charge until regulation reached
                st_nxt.chg = !i_flags.supply_at_reg;
                st_nxt.timer = '0;
                st_nxt.ramp = '0;
                if (i_flags.supply_start && !f.thermal_guard && !i_flags.supply_over) begin
                    st_nxt.phase = ST_SOFT;
                    st_nxt.fault = '0;
                end
            end
            ST_SOFT, ST_RUN: begin
                st_nxt.chg = 1'b0;
                if (any_fault) begin
                    // Stop at once, latch cause for status
                    st_nxt.phase = ST_PROTECT;
                    st_nxt.fault = f;
                    st_nxt.sw_on = 1'b0;
                    st_nxt.timer = '0;
                end else if (st_r.phase == ST_SOFT) begin
                    st_nxt.timer = st_r.timer + 1'b1;
                    // Current limit climbs in equal steps
                    if (st_r.timer >= ss_step * TW'(st_r.ramp + 1'b1)
                            && st_r.ramp != '1) begin
                        st_nxt.ramp = st_r.ramp + 1'b1;
                    end
                    if (st_r.timer >= TW'(SOFT_START_CNT)) begin
                        st_nxt.phase = ST_RUN;
                        st_nxt.ramp = '1;
                    end
                end
            end
            ST_PROTECT: begin
                // Supply held at regulation while timing runs
                st_nxt.chg = 1'b0;
                st_nxt.timer = st_r.timer + 1'b1;
                if (st_r.timer >= TW'(RESTART_CNT - 1)) begin
                    st_nxt.phase = ST_DECAY;
                    st_nxt.timer = '0;
                end
            end
            ST_DECAY: begin
                st_nxt.chg = 1'b0;
                st_nxt.reg_on = 1'b0;
                if (i_flags.supply_stop) begin
                    // Protection cleared, recharge from drain
                    st_nxt.phase = ST_CHARGE;
                    st_nxt.chg = 1'b1;
                    st_nxt.abn_cnt = 2'h0;
                end
            end
            default: begin
                st_nxt.phase = ST_CHARGE;
            end
        endcase
    end

    // State register with clock enable
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st_r <= '{phase: ST_CHARGE, lfsr: LFSR_SEED, chg: 1'b1, reg_on: 1'b1,
                      period: PW'(PERIOD_CNT), default: '0};
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    // Outputs from flip-flops
    assign o_switch_on = st_r.sw_on && switching;
    assign o_sense_enable = st_r.sw_on && !blank_active;
    assign o_charge_current_source = st_r.chg;
    assign o_supply_regulator = st_r.reg_on && (st_r.phase != ST_DECAY);
    assign o_current_ramp = st_r.ramp;
    assign o_fault = st_r.fault;
    assign o_phase = st_r.phase;

endmodule

//--- rtl/switcher_pkg.sv
// Purpose: Shared constants and carriers for the switcher fault and auto-restart controller
// Assumes: Analog comparators deliver clean flags synchronous to i_ref_clk
// Notes on behaviour
// - Charge source on until supply reaches regulation or switching starts
// - Regulator off while external bias above regulation
// - Ignore current sense during turn-on blanking
// - Pseudo-random frequency from feedback and free oscillator
// - Any fault stops switching, auto-restart only
// - Regulate supply while protection timing runs
// - Count restart interval then disable regulator
// - At stop threshold clear protection, recharge supply
// - At start threshold resume switching, repeat cycle
// - Overload level held through delay is fault
// - Four abnormal current cycles raise fault
// - Thermal fault until temperature falls by hysteresis
// - Supply over-voltage raises fault, stops switching
// - Feedback below open-loop level raises fault
// - Open-loop guard disabled during soft-start
// - Permitted switch current ramps over soft-start
package switcher_pkg;

    // Clock rate and times
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned OVERLOAD_DELAY_MS = 40;
    localparam int unsigned RESTART_TIME_MS = 650;
    localparam int unsigned SOFT_START_MS = 10;
    localparam int unsigned BLANKING_TIME_NS = 200;
    localparam int unsigned SWITCH_FREQ_HZ = 50_000;
    localparam int unsigned OVERLOAD_CYCLES = OVERLOAD_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned RESTART_CYCLES = RESTART_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned SOFT_START_CYCLES = SOFT_START_MS * (CLK_HZ / 1000);
    localparam int unsigned BLANKING_CYCLES =
        (BLANKING_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PERIOD_CYCLES = CLK_HZ / SWITCH_FREQ_HZ;
    // Maximum duty: turn-on limit within the period
    localparam int unsigned MAX_ON_CYCLES = (PERIOD_CYCLES * 2) / 3;
    // Frequency dither span in clock cycles, split about the nominal period
    localparam int unsigned DITHER_SPAN = 32;
    // Abnormal current cycle count that trips
    localparam logic [1:0] ABN_TRIP_COUNT = 2'h3;
    // Soft-start current ramp width in bits
    localparam int unsigned RAMP_W = 4;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    localparam logic [15:0] LFSR_TAPS = 16'hB400;

    // Phases of the supply and restart sequence
    typedef enum logic [4:0] {
        ST_CHARGE = 5'h01,
        ST_SOFT = 5'h02,
        ST_RUN = 5'h04,
        ST_PROTECT = 5'h08,
        ST_DECAY = 5'h10
    } phase_e;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic supply_at_reg;       // Supply at or above 10 V regulation
        logic supply_above_reg;    // External bias holds supply above 10 V
        logic supply_start;        // Supply reached 8 V start threshold
        logic supply_stop;         // Supply fell to 7 V stop threshold
        logic supply_over;         // Supply above 24.5 V
        logic comp_overload;       // Compensation at 3 V
        logic feedback_low;        // Feedback below 0.5 V
        logic sense_trip;          // Current sense reached PWM level
        logic sense_abnormal;      // Sense above abnormal current level
        logic temp_hot;            // Junction above 135 C
        logic temp_cooled;         // Junction cooled by hysteresis
        logic feedback_dither;     // Feedback-derived random bit
    } front_flags_s;

    // Fault flags
    typedef struct packed {
        logic overload_guard;
        logic abnormal_overcurrent_guard;
        logic thermal_guard;
        logic supply_overvoltage_guard;
        logic open_loop_guard;
        logic supply_lockout;
    } fault_s;

endpackage

//--- sim/switcher_ctrl_properties.sv
// Purpose: Port assertions for the switcher fault controller
// Assumes: Checks pause while clock enable is low
// Notes: Bound into every controller instance
`timescale 1ns/100ps
module switcher_ctrl_properties
    import switcher_pkg::*;
#(
    parameter int unsigned RESTART_CNT = RESTART_CYCLES
) (
    // Clock, reset and flags
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    input wire logic i_clk_en,
    input wire front_flags_s i_flags,
    // Controller outputs
    input wire logic o_switch_on,
    input wire logic o_sense_enable,
    input wire logic o_charge_current_source,
    input wire logic o_supply_regulator,
    input wire fault_s o_fault,
    input wire phase_e o_phase
);
    int unsigned dwell_r;
    int unsigned dwell_nxt;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn || !i_clk_en);
    // Protection dwell count; a stuck restart timer shows here
    always_comb dwell_nxt = (o_phase == ST_PROTECT) ? dwell_r + 1 : 0;
    always_ff @(posedge i_ref_clk) dwell_r <= i_rstn ? dwell_nxt : 0;

    property p_switch_off;
        o_phase inside {ST_CHARGE, ST_PROTECT, ST_DECAY} |-> !o_switch_on;
    endproperty
    a_switch_off: assert property (p_switch_off) else $error("switch on when stopped");
    property p_restart_len;
        $rose(o_phase == ST_DECAY) |-> dwell_r >= RESTART_CNT && dwell_r <= RESTART_CNT + 1;
    endproperty
    a_restart_len: assert property (p_restart_len) else $error("restart dwell wrong");
    property p_ext_bias;
        i_flags.supply_above_reg |=> !o_supply_regulator;
    endproperty
    a_ext_bias: assert property (p_ext_bias) else $error("regulator on with bias");
    property p_stop_recharge;
        o_phase == ST_DECAY && i_flags.supply_stop |=> o_phase == ST_CHARGE && o_charge_current_source;
    endproperty
    a_stop_recharge: assert property (p_stop_recharge) else $error("no recharge");
    property p_overvolt;
        o_phase inside {ST_SOFT, ST_RUN} && i_flags.supply_over
            |=> o_phase == ST_PROTECT && o_fault.supply_overvoltage_guard;
    endproperty
    a_overvolt: assert property (p_overvolt) else $error("overvoltage missed");
    property p_open_loop;
        o_phase == ST_RUN && i_flags.feedback_low |=> o_phase == ST_PROTECT && o_fault.open_loop_guard;
    endproperty
    a_open_loop: assert property (p_open_loop) else $error("open loop missed");
    property p_soft_no_ol;
        o_phase == ST_SOFT && i_flags.feedback_low |=> !o_fault.open_loop_guard;
    endproperty
    a_soft_no_ol: assert property (p_soft_no_ol) else $error("open loop in soft-start");
    property p_blank;
        $rose(o_switch_on) |-> !o_sense_enable [*4];
    endproperty
    a_blank: assert property (p_blank) else $error("sense honoured in blanking");
    property p_cause_kept;
        $rose(o_phase == ST_PROTECT) |-> o_fault != 6'h00;
    endproperty
    a_cause_kept: assert property (p_cause_kept) else $error("protect without cause");
endmodule

bind switcher_fault_autorestart_ctrl switcher_ctrl_properties #(.RESTART_CNT(RESTART_CNT)) u_props (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(i_clk_en), .i_flags(i_flags),
    .o_switch_on(o_switch_on), .o_sense_enable(o_sense_enable),
    .o_charge_current_source(o_charge_current_source),
    .o_supply_regulator(o_supply_regulator), .o_fault(o_fault), .o_phase(o_phase)
);

//--- sim/front_end_model.sv
// Purpose: Behavioural supply and comparator front end
// Assumes: Supply in tenths of a volt, moving 0.5 V a clock
// Notes: Bench forces fault flags through i_force
`timescale 1ns/100ps
module front_end_model
    import switcher_pkg::*;
(
    // Clock and controller outputs
    input wire logic i_ref_clk,
    input wire logic i_switch_on,
    input wire logic i_charge_current_source,
    input wire logic i_supply_regulator,
    // Bench controls
    input wire logic i_ext_bias,
    input wire front_flags_s i_force,
    // Comparator flags
    output front_flags_s o_flags
);
    int vcc = 0;
    int on_cnt = 0;
    logic [7:0] osc = 8'h00;
    // Supply rises while fed, decays once both feeds are off
    always @(posedge i_ref_clk) begin
        osc <= osc + 8'h01;
        on_cnt <= i_switch_on ? on_cnt + 1 : 0;
        if (i_ext_bias)
            vcc <= 120;
        else if (i_charge_current_source || i_supply_regulator)
            vcc <= (vcc < 100) ? vcc + 5 : vcc;
        else if (vcc > 0)
            vcc <= vcc - 5;
    end
    // Thresholds; abnormal sense only shows past the turn-on spike
    always_comb begin
        o_flags = i_force;
        o_flags.supply_at_reg = vcc >= 100;
        o_flags.supply_above_reg = vcc > 100;
        o_flags.supply_start = vcc >= 80;
        o_flags.supply_stop = i_force.supply_stop || vcc <= 70;
        o_flags.sense_trip = i_switch_on && on_cnt >= 12;
        o_flags.sense_abnormal = i_force.sense_abnormal && i_switch_on && on_cnt >= 6;
        o_flags.feedback_dither = osc[3];
    end
endmodule

//--- sim/switcher_fault_autorestart_ctrl_tb.sv
// Purpose: Self-checking bench for the switcher fault controller
// Assumes: Shortened timer parameters
// Notes: Every fault cause runs one full auto-restart cycle
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module switcher_fault_autorestart_ctrl_tb;
    import switcher_pkg::*;
    localparam int unsigned OVL_N = 50;
    localparam int unsigned RST_N = 100;
    localparam int unsigned SS_N = 64;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic ext_bias = 1'b0;
    logic clk_en = 1'b1;
    front_flags_s fault_force = '0;
    front_flags_s flags;
    logic sw_on, sense_en, charge_src, regulator;
    logic [RAMP_W-1:0] ramp;
    fault_s fault;
    phase_e phase;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    // Per cause: forced flag, latched fault bit, latency window
    int flag_bit[6] = '{6, 3, 2, 7, 5, 8};
    int fault_bit[6] = '{5, 4, 3, 2, 1, 0};
    int lat_min[6] = '{OVL_N, 60, 1, 1, 1, 1};
    int lat_max[6] = '{OVL_N + 3, 300, 3, 3, 3, 3};

    switcher_fault_autorestart_ctrl #(.OVERLOAD_CNT(OVL_N), .RESTART_CNT(RST_N),
        .SOFT_START_CNT(SS_N), .PERIOD_CNT(40), .MAX_ON_CNT(26), .BLANK_CNT(5)) uut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_clk_en(clk_en), .i_flags(flags),
        .o_switch_on(sw_on), .o_sense_enable(sense_en), .o_charge_current_source(charge_src),
        .o_supply_regulator(regulator), .o_current_ramp(ramp), .o_fault(fault), .o_phase(phase));
    front_end_model u_front (.i_ref_clk(i_ref_clk), .i_switch_on(sw_on),
        .i_charge_current_source(charge_src), .i_supply_regulator(regulator),
        .i_ext_bias(ext_bias), .i_force(fault_force), .o_flags(flags));

    // 25 MHz clock
    initial forever #20 i_ref_clk = ~i_ref_clk;
    // Hang guard, far above the expected run length
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bounded wait for a phase; n returns the cycles taken
    task automatic wait_phase(input phase_e p, input int lim, output int n);
        n = 0;
        while (phase !== p && n < lim) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic t_startup();
        int n;
        logic [RAMP_W-1:0] ramp0;
        `CHK("charge_src", 1'b1, charge_src)
        wait_phase(ST_SOFT, 100, n);
        ramp0 = ramp;
        wait_phase(ST_RUN, SS_N + 10, n);
        `CHK("soft_len", 1'b1, n >= SS_N - 1 && n <= SS_N + 1)
        `CHK("ramp_up", 1'b1, ramp > ramp0)
        $display("startup test done");
    endtask

    task automatic t_ext_bias();
        ext_bias = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        #1;
        `CHK("reg_bias", 1'b0, regulator)
        ext_bias = 1'b0;
        repeat (10) @(posedge i_ref_clk);
        #1;
        `CHK("reg_back", 1'b1, regulator)
        $display("bias test done");
    endtask

    // Overload held past its delay while frozen must not trip
    task automatic t_freeze();
        logic sw0;
        sw0 = sw_on;
        clk_en = 1'b0;
        fault_force.comp_overload = 1'b1;
        repeat (OVL_N + 20) @(posedge i_ref_clk);
        #1;
        `CHK("frz_phase", ST_RUN, phase)
        `CHK("frz_sw", sw0, sw_on)
        `CHK("frz_fault", 6'h00, fault)
        fault_force.comp_overload = 1'b0;
        clk_en = 1'b1;
        @(posedge i_ref_clk);
        #1;
        $display("freeze test done");
    endtask

    task automatic t_fault(input int k);
        int n;
        fault_s exp_fault;
        exp_fault = '0;
        exp_fault[fault_bit[k]] = 1'b1;
        // Open loop is held through soft-start, where it must be ignored
        if (k == 4) fault_force.feedback_low = 1'b1;
        wait_phase(ST_RUN, SS_N + 100, n);
        fault_force[flag_bit[k]] = 1'b1;
        wait_phase(ST_PROTECT, 400, n);
        `CHK("latency", 1'b1, n >= lat_min[k] && n <= lat_max[k])
        `CHK("cause", exp_fault, fault)
        `CHK("sw_off", 1'b0, sw_on)
        `CHK("reg_on", 1'b1, regulator)
        fault_force = '0;
        wait_phase(ST_DECAY, RST_N + 10, n);
        `CHK("reg_off", 1'b0, regulator)
        wait_phase(ST_CHARGE, 50, n);
        `CHK("recharge", 1'b1, charge_src)
        if (k == 2) begin
            repeat (30) @(posedge i_ref_clk);
            #1;
            `CHK("hot_hold", ST_CHARGE, phase)
            fault_force.temp_cooled = 1'b1;
            wait_phase(ST_SOFT, 10, n);
            fault_force.temp_cooled = 1'b0;
            `CHK("cool_go", ST_SOFT, phase)
        end
        $display("fault test %0d done", k);
    endtask

    initial begin
        repeat (10) @(posedge i_ref_clk);
        #1;
        i_rstn = 1'b1;
        t_startup();
        t_ext_bias();
        t_freeze();
        for (int k = 0; k < 6; k++) begin
            t_fault(k);
        end
        tally_and_finish();
    end
endmodule
